// ==== shared/bdp_pkg.sv ====
/*
  package for the booster diagnostic and power-state block: register
  indices, field positions, reset values, state codes and timing counts.
  assumes a 40 MHz core clock and a 32-bit apb register bus.
*/
`default_nettype none
package bdp_pkg;
  // clock rate and documented times
  localparam int unsigned CLK_MHZ      = 40;
  localparam int unsigned INIT_TIME_US = 150;
  localparam int unsigned BLANK_TIME_US = 150;
  localparam int unsigned OPER_TIME_US = 500;
  localparam int unsigned INIT_CYC     = INIT_TIME_US * CLK_MHZ;
  localparam int unsigned BLANK_CYC    = BLANK_TIME_US * CLK_MHZ;
  localparam int unsigned OPER_CYC     = OPER_TIME_US * CLK_MHZ;
  localparam int unsigned TMR_W        = 16;

  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX  = 8'h00;
  localparam logic [7:0] STATA_IDX = 8'h0a;
  localparam logic [7:0] STATB_IDX = 8'h0b;

  // control register fields
  localparam int unsigned CTRL_PHASE_EN_LSB = 0;
  localparam int unsigned CTRL_AUTO_REC_BIT = 8;
  localparam int unsigned CTRL_PIN_SEL_BIT  = 9;
  localparam int unsigned CTRL_KEEP_BIT     = 10;
  localparam int unsigned CTRL_TTHR_LSB     = 12;
  localparam int unsigned CTRL_GTHR_LSB     = 16;
  localparam int unsigned CTRL_GSET_LSB     = 20;
  localparam logic [3:0]  GSET_RESET        = 4'h0;

  // status register a fields
  localparam int unsigned STA_TW_BIT     = 0;
  localparam int unsigned STA_TSD_BIT    = 1;
  localparam int unsigned STA_TOUT_BIT   = 2;
  localparam int unsigned STA_SERR_BIT   = 3;
  localparam int unsigned STA_HWR_BIT    = 4;
  localparam int unsigned STA_OV_BIT     = 5;
  localparam int unsigned STA_RUN_LSB    = 8;

  // status register b fields
  localparam int unsigned STB_DUV_BIT    = 0;
  localparam int unsigned STB_GFLT_BIT   = 1;
  localparam int unsigned STB_PIN_LSB    = 8;

  // power states, one-hot
  typedef enum logic [3:0] {
    BDP_RESET  = 4'b0001,
    BDP_INIT   = 4'b0010,
    BDP_NORMAL = 4'b0100,
    BDP_FSAFE  = 4'b1000
  } bdp_state_t;
endpackage
`default_nettype wire

// ==== shared/bdp_tmr_if.sv ====
/*
  interface between the power-state logic and its elapsed-time counter.
  assumes both ends run on the same core clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface bdp_tmr_if #(parameter int unsigned W = 16);
  logic         restart;  // clears the count
  logic [W-1:0] elapsed;  // cycles since restart, saturating
  modport ctrl (output restart, input elapsed);
  modport tmr  (input restart, output elapsed);
endinterface
`default_nettype wire

// ==== core/bdp_elapsed.sv ====
/*
  saturating elapsed-cycle counter, restarted through the timer interface.
  assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module bdp_elapsed
  import bdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  bdp_tmr_if.tmr   tmr
);
  // count up from zero after reset or restart, stop at all ones
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr.elapsed <= '0;
    end else if (tmr.restart) begin
      tmr.elapsed <= '0;
    end else if (~&tmr.elapsed) begin
      tmr.elapsed <= tmr.elapsed + 1'b1;
    end
  end
endmodule // bdp_elapsed
`default_nettype wire

// ==== core/bdp_top.sv ====
/*
  booster diagnostic flags, per-phase protection and power-state sequence,
  with an apb slave for control and status.
  assumes comparator, supply monitor and pin inputs synchronous to core_clk,
  and serial_err as a one-cycle pulse per framing or parity error.
*/
`timescale 1ns/100ps
`default_nettype none
module bdp_top
  import bdp_pkg::*;
#(
  parameter int unsigned N_PHASE    = 2,
  parameter int unsigned INIT_CNT   = INIT_CYC,
  parameter int unsigned BLANK_CNT  = BLANK_CYC,
  parameter int unsigned OPER_CNT   = OPER_CYC
)(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  // analog monitors and events
  input  wire logic               tw_cmp,
  input  wire logic               tsd_cmp,
  input  wire logic [2:0]         temp_level,
  input  wire logic               serial_err,
  input  wire logic               ov_trip,
  input  wire logic               ov_below_react,
  input  wire logic               divider_uv,
  input  wire logic               gate_headroom_low,
  input  wire logic               gate_current_bad,
  input  wire logic [3:0]         gate_supply_level,
  input  wire logic               battery_ok,
  input  wire logic               core_supply_ok,
  input  wire logic [N_PHASE-1:0] phase_enable_pin,
  input  wire logic [2:0]         otp_mode_sel,
  input  wire logic               otp_lock,
  // outputs
  output var  logic [N_PHASE-1:0] phase_gate_en,
  output var  logic               core_reg_en,
  output var  logic               fail_safe_mode,
  output var  logic               fully_operational
);
  localparam logic [TMR_W-1:0] INIT_T  = TMR_W'(INIT_CNT);
  localparam logic [TMR_W-1:0] BLANK_T = TMR_W'(BLANK_CNT);
  localparam logic [TMR_W-1:0] OPER_T  = TMR_W'(OPER_CNT);

  // word index of an apb byte address, or all ones when misaligned
  function automatic logic [7:0] reg_index(input logic [7:0] a);
    reg_index = (a[1:0] == 2'b00) ? {2'b00, a[7:2]} : 8'hff;
  endfunction

  bdp_state_t         state_reg;
  bdp_state_t         state_next;
  logic [N_PHASE-1:0] phase_en_reg;
  logic [N_PHASE-1:0] phase_en_prev_reg;
  logic               auto_rec_reg;
  logic               pin_sel_reg;
  logic               keep_alive_reg;
  logic [2:0]         temp_thr_reg;
  logic [2:0]         gate_thr_reg;
  logic [3:0]         gate_set_reg;
  logic               tw_flag_reg;
  logic               tsd_flag_reg;
  logic               tout_flag_reg;
  logic               serr_flag_reg;
  logic               hwr_flag_reg;
  logic               ov_flag_reg;
  logic               duv_flag_reg;
  logic               gflt_flag_reg;
  logic               tsd_active_reg;
  logic               ov_active_reg;
  logic [N_PHASE-1:0] tsd_lock_reg;
  logic [N_PHASE-1:0] duv_lock_reg;
  logic [N_PHASE-1:0] glo_lock_reg;
  logic [N_PHASE-1:0] pin_level_reg;
  logic [N_PHASE-1:0] bit_eff;
  logic [N_PHASE-1:0] bit_rise;
  logic               wr_done;
  logic               rd_done;
  logic [7:0]         acc_idx;
  logic               auto_eff;
  logic               glo_cond;
  logic               blank_done;
  logic               any_pin;
  logic               supplies_ok;
  logic               rd_stata;
  logic               rd_statb;

  bdp_tmr_if #(.W(TMR_W)) por_tmr ();
  bdp_tmr_if #(.W(TMR_W)) seq_tmr ();

  // time since reset release, used to blank the gate lockout
  bdp_elapsed u_por_tmr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tmr      (por_tmr)
  );

  // time since the reset state was left or a pin rose
  bdp_elapsed u_seq_tmr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tmr      (seq_tmr)
  );

  // apb decode; a transfer completes on the access edge
  assign acc_idx  = reg_index(paddr);
  assign wr_done  = psel & penable & pready & pwrite;
  assign rd_done  = psel & penable & pready & ~pwrite;
  assign rd_stata = rd_done & (acc_idx == STATA_IDX);
  assign rd_statb = rd_done & (acc_idx == STATB_IDX);

  // answer one cycle after setup, error on unmapped index
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (acc_idx != CTRL_IDX) &
                 (acc_idx != STATA_IDX) & (acc_idx != STATB_IDX);
      prdata  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        unique case (acc_idx)
          CTRL_IDX: begin
            prdata[CTRL_PHASE_EN_LSB +: N_PHASE] <= phase_en_reg;
            prdata[CTRL_AUTO_REC_BIT]            <= auto_rec_reg;
            prdata[CTRL_PIN_SEL_BIT]             <= pin_sel_reg;
            prdata[CTRL_KEEP_BIT]                <= keep_alive_reg;
            prdata[CTRL_TTHR_LSB +: 3]           <= temp_thr_reg;
            prdata[CTRL_GTHR_LSB +: 3]           <= gate_thr_reg;
            prdata[CTRL_GSET_LSB +: 4]           <= gate_set_reg;
          end
          STATA_IDX: begin
            prdata[STA_TW_BIT]              <= tw_flag_reg;
            prdata[STA_TSD_BIT]             <= tsd_flag_reg;
            prdata[STA_TOUT_BIT]            <= tout_flag_reg;
            prdata[STA_SERR_BIT]            <= serr_flag_reg;
            prdata[STA_HWR_BIT]             <= hwr_flag_reg;
            prdata[STA_OV_BIT]              <= ov_flag_reg;
            prdata[STA_RUN_LSB +: N_PHASE]  <= phase_gate_en;
          end
          STATB_IDX: begin
            prdata[STB_DUV_BIT]             <= duv_flag_reg;
            prdata[STB_GFLT_BIT]            <= gflt_flag_reg;
            prdata[STB_PIN_LSB +: N_PHASE]  <= pin_level_reg;
          end
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register; fail-safe forces the effective enable high, not these bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_en_reg   <= '0;
      auto_rec_reg   <= 1'b0;
      pin_sel_reg    <= 1'b0;
      keep_alive_reg <= 1'b0;
      temp_thr_reg   <= 3'h0;
      gate_thr_reg   <= 3'h0;
      gate_set_reg   <= GSET_RESET;
    end else if (wr_done && acc_idx == CTRL_IDX) begin
      phase_en_reg   <= pwdata[CTRL_PHASE_EN_LSB +: N_PHASE];
      auto_rec_reg   <= pwdata[CTRL_AUTO_REC_BIT];
      pin_sel_reg    <= pwdata[CTRL_PIN_SEL_BIT];
      keep_alive_reg <= pwdata[CTRL_KEEP_BIT];
      temp_thr_reg   <= pwdata[CTRL_TTHR_LSB +: 3];
      gate_thr_reg   <= pwdata[CTRL_GTHR_LSB +: 3];
      gate_set_reg   <= pwdata[CTRL_GSET_LSB +: 4];
    end
  end

  // effective enable and its rising edge, sampled every cycle
  assign bit_eff  = fail_safe_mode ? {N_PHASE{1'b1}} : phase_en_reg;
  assign bit_rise = bit_eff & ~phase_en_prev_reg;
  assign auto_eff = auto_rec_reg | fail_safe_mode;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_en_prev_reg <= '0;
      pin_level_reg     <= '0;
    end else begin
      phase_en_prev_reg <= bit_eff;
      pin_level_reg     <= phase_enable_pin;
    end
  end

  // latched flags: hardware set wins over the read clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tw_flag_reg   <= 1'b0;
      tsd_flag_reg  <= 1'b0;
      tout_flag_reg <= 1'b0;
      serr_flag_reg <= 1'b0;
      hwr_flag_reg  <= 1'b1;
      ov_flag_reg   <= 1'b0;
    end else begin
      tw_flag_reg   <= tw_cmp | (tw_flag_reg & ~rd_stata);
      tsd_flag_reg  <= tsd_cmp | (tsd_flag_reg & ~rd_stata);
      tout_flag_reg <= (temp_level > temp_thr_reg) |
                       (tout_flag_reg & ~rd_stata);
      serr_flag_reg <= serial_err | (serr_flag_reg & ~rd_stata);
      hwr_flag_reg  <= hwr_flag_reg & ~rd_stata;
      ov_flag_reg   <= ov_trip | (ov_flag_reg & ~rd_stata);
    end
  end

  // status b latched flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      duv_flag_reg  <= 1'b0;
      gflt_flag_reg <= 1'b0;
    end else begin
      duv_flag_reg  <= divider_uv | (duv_flag_reg & ~rd_statb);
      gflt_flag_reg <= gate_headroom_low | gate_current_bad |
                       (gflt_flag_reg & ~rd_statb);
    end
  end

  // global shutdown conditions with their own exit levels
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tsd_active_reg <= 1'b0;
      ov_active_reg  <= 1'b0;
    end else begin
      if (tsd_cmp) begin
        tsd_active_reg <= 1'b1;
      end else if (!tw_cmp) begin
        tsd_active_reg <= 1'b0;
      end
      if (ov_trip) begin
        ov_active_reg <= 1'b1;
      end else if (ov_below_react) begin
        ov_active_reg <= 1'b0;
      end
    end
  end

  // gate lockout: at or below setpoint minus threshold, after blanking
  assign blank_done = (por_tmr.elapsed >= BLANK_T);
  assign glo_cond   = blank_done & (gate_thr_reg != 3'h0) &
                      ({1'b0, gate_supply_level} + {2'b00, gate_thr_reg} <=
                       {1'b0, gate_set_reg});
  assign por_tmr.restart = 1'b0;

  // per-phase recovery locks and gate enable
  genvar gi;
  generate
    for (gi = 0; gi < N_PHASE; gi++) begin : g_phase
      logic pin_ok;
      logic tsd_rec;
      assign pin_ok = ~pin_sel_reg | phase_enable_pin[gi];
      // auto: bit held high; manual: bit edge when cool and flag read
      assign tsd_rec = ~tsd_active_reg & pin_ok &
                       (auto_eff ? bit_eff[gi]
                                 : (bit_rise[gi] & ~tw_cmp &
                                    ~tsd_flag_reg));

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          tsd_lock_reg[gi] <= 1'b0;
          duv_lock_reg[gi] <= 1'b0;
          glo_lock_reg[gi] <= 1'b0;
        end else begin
          if (tsd_cmp) begin
            tsd_lock_reg[gi] <= 1'b1;
          end else if (tsd_rec) begin
            tsd_lock_reg[gi] <= 1'b0;
          end
          if (divider_uv) begin
            duv_lock_reg[gi] <= 1'b1;
          end else if (bit_rise[gi]) begin
            duv_lock_reg[gi] <= 1'b0;
          end
          if (glo_cond) begin
            glo_lock_reg[gi] <= 1'b1;
          end else if (bit_rise[gi]) begin
            glo_lock_reg[gi] <= 1'b0;
          end
        end
      end

      // run only when active, enabled and free of every lock
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          phase_gate_en[gi] <= 1'b0;
        end else begin
          phase_gate_en[gi] <= (state_reg == BDP_NORMAL ||
                                state_reg == BDP_FSAFE) &
                               bit_eff[gi] & pin_ok &
                               ~tsd_lock_reg[gi] & ~tsd_active_reg &
                               ~tsd_cmp & ~ov_active_reg & ~ov_trip &
                               ~duv_lock_reg[gi] & ~divider_uv &
                               ~glo_lock_reg[gi] & ~glo_cond;
        end
      end
    end
  endgenerate

  // power-state sequence
  assign any_pin     = |phase_enable_pin;
  assign supplies_ok = battery_ok & core_supply_ok;
  assign seq_tmr.restart = (state_reg == BDP_RESET) |
                           (|(phase_enable_pin & ~pin_level_reg));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BDP_RESET: begin
        if (supplies_ok && any_pin) begin
          state_next = BDP_INIT;
        end
      end
      BDP_INIT: begin
        if (!supplies_ok) begin
          state_next = BDP_RESET;
        end else if (seq_tmr.elapsed >= INIT_T) begin
          state_next = (otp_lock && otp_mode_sel != 3'h0) ?
                       BDP_FSAFE : BDP_NORMAL;
        end
      end
      BDP_NORMAL, BDP_FSAFE: begin
        if (!supplies_ok || (!keep_alive_reg && !any_pin)) begin
          state_next = BDP_RESET;
        end
      end
      default: state_next = BDP_RESET;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BDP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // registered state outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reg_en       <= 1'b0;
      fail_safe_mode    <= 1'b0;
      fully_operational <= 1'b0;
    end else begin
      core_reg_en       <= (state_next != BDP_RESET);
      fail_safe_mode    <= (state_next == BDP_FSAFE);
      fully_operational <= (state_next == BDP_NORMAL ||
                            state_next == BDP_FSAFE) &
                           (seq_tmr.elapsed >= OPER_T);
    end
  end
endmodule // bdp_top
`default_nettype wire

// ==== tb/bdp_apb_host.sv ====
/*
  apb host model that stands in for the microcontroller side.
  assumes the bench calls xfer and a slave that answers with pready.
*/
`timescale 1ns/100ps
`default_nettype none
module bdp_apb_host (
  input  wire logic        core_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one whole transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // wait for the answer; only the bench watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;  // released lines stop showing old value
    pwdata <= ~d;
  endtask
endmodule // bdp_apb_host
`default_nettype wire

// ==== tb/bdp_top_asserts.sv ====
/*
  port-level assertions for bdp_top, bound into every instance.
  assumes the single core_clk domain with async active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module bdp_top_asserts
  import bdp_pkg::*;
#(
  parameter int unsigned N_PHASE = 2
)(
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               tsd_cmp,
  input wire logic               ov_trip,
  input wire logic               divider_uv,
  input wire logic               battery_ok,
  input wire logic               core_supply_ok,
  input wire logic [N_PHASE-1:0] phase_enable_pin,
  input wire logic [2:0]         otp_mode_sel,
  input wire logic               otp_lock,
  input wire logic [N_PHASE-1:0] phase_gate_en,
  input wire logic               core_reg_en,
  input wire logic               fail_safe_mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // stop causes turn gates off on the next edge
  tsd_stop_a: assert property (tsd_cmp |=> phase_gate_en == '0) else $error("gate on in shutdown");
  ov_stop_a: assert property (ov_trip |=> phase_gate_en == '0) else $error("gate on in overvoltage");
  uv_stop_a: assert property (divider_uv |=> phase_gate_en == '0) else $error("gate on in uv");
  // bus answer timing
  ready_setup_a: assert property (psel && !penable |=> pready && penable) else $error("late pready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  // regulator only on good supplies with a pin high, off when cause gone
  reg_on_a: assert property ($rose(core_reg_en) |->
    $past(battery_ok && core_supply_ok && (|phase_enable_pin))) else $error("bad start");
  reg_off_a: assert property ($fell(core_reg_en) |->
    $past(!(battery_ok && core_supply_ok) || !(|phase_enable_pin))) else $error("bad stop");
  fsafe_lock_a: assert property (fail_safe_mode |-> otp_lock && otp_mode_sel != 3'h0)
    else $error("fail-safe without lock");
  // main scenarios
  run_c: cover property (phase_gate_en == '1);
  tsd_c: cover property (tsd_cmp ##1 phase_gate_en == '0);
  err_c: cover property (pslverr);
endmodule // bdp_top_asserts
bind bdp_top bdp_top_asserts #(.N_PHASE(N_PHASE)) bdp_top_asserts_i (.core_clk, .rst_n,
  .psel, .penable, .prdata, .pready, .pslverr, .tsd_cmp, .ov_trip, .divider_uv,
  .battery_ok, .core_supply_ok, .phase_enable_pin, .otp_mode_sel, .otp_lock,
  .phase_gate_en, .core_reg_en, .fail_safe_mode);
`default_nettype wire

// ==== tb/bdp_top_tb_top.sv ====
/*
  self-checking bench for bdp_top with short timing counts.
  assumes the apb host model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module bdp_top_tb_top;
  import bdp_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic tw_cmp, tsd_cmp, serial_err, ov_trip, ov_below_react, divider_uv;
  logic gate_headroom_low, gate_current_bad, otp_lock, battery_ok, core_supply_ok;
  logic [2:0] temp_level, otp_mode_sel;
  logic [3:0] gate_supply_level;
  logic [1:0] phase_enable_pin, phase_gate_en;
  logic core_reg_en, fail_safe_mode, fully_operational;
  int n_errors = 0;
  int num_checks = 0;

  bdp_apb_host bdp_apb_host_i (.core_clk, .prdata, .pready, .pslverr, .psel,
    .penable, .pwrite, .paddr, .pwdata);
  bdp_top #(.INIT_CNT(20), .BLANK_CNT(20), .OPER_CNT(50)) bdp_top_i (.core_clk,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tw_cmp, .tsd_cmp, .temp_level, .serial_err, .ov_trip, .ov_below_react,
    .divider_uv, .gate_headroom_low, .gate_current_bad,
    .gate_supply_level, .battery_ok, .core_supply_ok, .phase_enable_pin,
    .otp_mode_sel, .otp_lock, .phase_gate_en, .core_reg_en,
    .fail_safe_mode, .fully_operational);

  // clock, 25 ns period
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    bdp_apb_host_i.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    bdp_apb_host_i.xfer(1'b0, a, 32'h0, r, e);
    chk("rdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask

  task automatic gchk(input logic [1:0] x);
    cyc(4);
    chk("gate", {30'h0, x}, {30'h0, phase_gate_en});
  endtask

  task automatic scen_reset;
    chk("reg_en", 32'h0, {31'h0, core_reg_en});
    rchk(8'h28, 32'h10, 1'b0);
    rchk(8'h28, 32'h0, 1'b0);
    rchk(8'h04, 32'h0, 1'b1);
    rchk(8'h29, 32'h0, 1'b1);
  endtask

  task automatic scen_power;
    phase_enable_pin <= 2'b11;
    cyc(2);
    chk("reg_en", 32'h1, {31'h0, core_reg_en});
    chk("full_op", 32'h0, {31'h0, fully_operational});
    cyc(25);
    gchk(2'b00);
    wr(8'h00, 32'h3);
    gchk(2'b11);
    rchk(8'h28, 32'h300, 1'b0);
    rchk(8'h2c, 32'h300, 1'b0);
    cyc(12);
    chk("full_op", 32'h1, {31'h0, fully_operational});
  endtask

  task automatic scen_tsd;
    tw_cmp <= 1'b1;
    tsd_cmp <= 1'b1;
    gchk(2'b00);
    tsd_cmp <= 1'b0;
    rchk(8'h28, 32'h3, 1'b0);
    gchk(2'b00);
    tw_cmp <= 1'b0;
    gchk(2'b00);
    rchk(8'h28, 32'h1, 1'b0);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h3);
    gchk(2'b11);
    wr(8'h00, 32'h103);
    tw_cmp <= 1'b1;
    tsd_cmp <= 1'b1;
    gchk(2'b00);
    tsd_cmp <= 1'b0;
    tw_cmp <= 1'b0;
    gchk(2'b11);
    rchk(8'h28, 32'h303, 1'b0);
  endtask

  task automatic scen_ov;
    ov_trip <= 1'b1;
    gchk(2'b00);
    ov_trip <= 1'b0;
    gchk(2'b00);
    ov_below_react <= 1'b1;
    gchk(2'b11);
    rchk(8'h28, 32'h320, 1'b0);
    serial_err <= 1'b1;
    cyc(1);
    serial_err <= 1'b0;
    gchk(2'b11);
    rchk(8'h28, 32'h308, 1'b0);
    temp_level <= 3'h1;
    cyc(2);
    temp_level <= 3'h0;
    rchk(8'h28, 32'h304, 1'b0);
  endtask

  task automatic scen_gate;
    gate_headroom_low <= 1'b1;
    cyc(2);
    gate_headroom_low <= 1'b0;
    gchk(2'b11);
    divider_uv <= 1'b1;
    gchk(2'b00);
    divider_uv <= 1'b0;
    gchk(2'b00);
    rchk(8'h2c, 32'h303, 1'b0);
    wr(8'h00, 32'h100);
    wr(8'h00, 32'h103);
    gchk(2'b11);
    // gate lockout: threshold 1 below setpoint 4
    wr(8'h00, 32'h0041_0103);
    gate_supply_level <= 4'h3;
    gchk(2'b00);
    gate_supply_level <= 4'hf;
    gchk(2'b00);
    wr(8'h00, 32'h0041_0100);
    wr(8'h00, 32'h0041_0103);
    gchk(2'b11);
    wr(8'h00, 32'h0040_0103);
    gate_supply_level <= 4'h3;
    gchk(2'b11);
    gate_supply_level <= 4'hf;
    gate_current_bad <= 1'b1;
    cyc(1);
    gate_current_bad <= 1'b0;
    rchk(8'h2c, 32'h302, 1'b0);
    // independent pin control
    wr(8'h00, 32'h203);
    phase_enable_pin <= 2'b01;
    gchk(2'b01);
    phase_enable_pin <= 2'b11;
  endtask

  task automatic scen_keep;
    wr(8'h00, 32'h403);
    phase_enable_pin <= 2'b00;
    cyc(4);
    chk("reg_en", 32'h1, {31'h0, core_reg_en});
    wr(8'h00, 32'h3);
    cyc(4);
    chk("reg_en", 32'h0, {31'h0, core_reg_en});
  endtask

  task automatic scen_fsafe;
    wr(8'h00, 32'h0);
    otp_lock <= 1'b1;
    otp_mode_sel <= 3'h6;
    phase_enable_pin <= 2'b11;
    cyc(30);
    chk("fsafe", 32'h1, {31'h0, fail_safe_mode});
    gchk(2'b11);
    tsd_cmp <= 1'b1;
    gchk(2'b00);
    tsd_cmp <= 1'b0;
    gchk(2'b11);
  endtask

  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    {tw_cmp, tsd_cmp, serial_err, ov_trip, ov_below_react} = 5'h0;
    divider_uv = 1'b0;
    gate_headroom_low = 1'b0;
    {gate_current_bad, otp_lock, otp_mode_sel, temp_level} = 8'h00;
    gate_supply_level = 4'hf;
    battery_ok = 1'b1;
    core_supply_ok = 1'b1;
    phase_enable_pin = 2'b00;
    cyc(2);
    rst_n <= 1'b1;
    scen_reset();
    scen_power();
    scen_tsd();
    scen_ov();
    scen_gate();
    scen_keep();
    scen_fsafe();
    print_verdict();
  end

  // watchdog
  initial begin
    #(25 * 5000);
    n_errors++;
    print_verdict();
  end
endmodule // bdp_top_tb_top
`default_nettype wire
